/* ldr_pkg.sv */
// Holds the constants of the loop diagnostic result register.
// Assumes every user refers to these names as ldr_pkg::name.
package ldr_pkg;
  // ---------------------------------------------------------------
  // Register identity and read command
  // ---------------------------------------------------------------
  localparam logic [7:0] LDR_REG_ID = 8'h37;
  localparam logic [15:0] LDR_READ_CODE = 16'h3700;
  localparam int LDR_REG_W = 20;
  localparam logic [19:0] LDR_RESULT_RESET = 20'h00000;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LDR_BIT_MODE = 19;
  localparam int LDR_BIT_RUN = 18;
  localparam int LDR_BIT_ZERO = 17;
  localparam int LDR_BIT_PRIOR = 16;
  localparam int LDR_BIT_SWITCH = 15;
  localparam int LDR_BIT_PATH = 14;
  localparam int LDR_BIT_ABOVE = 13;
  localparam int LDR_BIT_BELOW = 12;
  localparam int LDR_SEL_HI = 11;
  localparam int LDR_SEL_LO = 8;
  localparam int LDR_BIT_LOOP = 7;
  localparam int LDR_BIT_GROUND = 6;
  localparam int LDR_BIT_BATTERY = 5;
  localparam int LDR_BIT_PIN = 4;
  localparam int LDR_LEAK_HI = 3;
  localparam int LDR_LEAK_LO = 0;
  // ---------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------
  localparam logic [3:0] LDR_CH_MAX = 4'h7;
  localparam logic [3:0] LDR_CH_NONE = 4'hf;
  localparam logic [3:0] LDR_TEST_NONE = 4'h0;
  localparam logic [3:0] LDR_TEST_UNUSED = 4'h4;
  localparam logic [3:0] LDR_NIBBLE_ZERO = 4'h0;
  typedef enum logic {
    LDR_IDLE = 1'b0,
    LDR_ANSWER = 1'b1
  } ldr_rd_state_t;
endpackage : ldr_pkg

/* ldr_res_if.sv */
// Carries the assembled result word from the register bank to its read port.
// Assumes one source and one sink on the same clock.
`timescale 1ns/1ps
interface ldr_res_if;
  logic [19:0] result;
  modport src (output result);
  modport snk (input result);
endinterface : ldr_res_if

/* ldr_read_port.sv */
// Holds the read command decoder and the answer register.
// Assumes commands arrive synchronous to clk, one per cycle at most.
`timescale 1ns/1ps
module ldr_read_port (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  ldr_res_if.snk res,
  output logic rsp_valid,
  output logic [19:0] rsp_data,
  output logic cmd_refused
);
  ldr_pkg::ldr_rd_state_t state_q;
  logic refused_q;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ldr_pkg::LDR_IDLE;
    end else begin
      case (state_q)
        ldr_pkg::LDR_IDLE: begin
          if (cmd_valid && cmd_code == ldr_pkg::LDR_READ_CODE) begin
            state_q <= ldr_pkg::LDR_ANSWER;
          end
        end
        ldr_pkg::LDR_ANSWER: begin
          if (!(cmd_valid && cmd_code == ldr_pkg::LDR_READ_CODE)) begin
            state_q <= ldr_pkg::LDR_IDLE;
          end
        end
        default: begin
          state_q <= ldr_pkg::LDR_IDLE;
        end
      endcase
    end
  end

  // A snapshot is taken so the answer cannot tear if the bank updates mid-frame.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_data <= ldr_pkg::LDR_RESULT_RESET;
    end else if (cmd_valid && cmd_code == ldr_pkg::LDR_READ_CODE) begin
      rsp_data <= res.result;
    end
  end

  // Any other code, write codes included, has no effect on the bank.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= cmd_valid && cmd_code != ldr_pkg::LDR_READ_CODE;
    end
  end

  assign rsp_valid = state_q == ldr_pkg::LDR_ANSWER;
  assign cmd_refused = refused_q;
endmodule : ldr_read_port

/* loop_diag_result.sv */
// Holds the loop diagnostic result register bank and its read answer.
// Assumes the loop diagnostic state machine and the leakage, resistance and
// driver tests drive the event inputs synchronous to clk.
`timescale 1ns/1ps
// Behaviour
// - Register is read only, answered on read code; no write effect exists.
// - Bit 19 gives diagnostic mode, reads zero in low-level mode.
// - Bit 18 is one while a high-level test runs; clears on state reset.
// - Bit 16 flags a fault present before the diagnostic started.
// - Bit 15 set when a high or low FET switches on in diagnostics.
// - Bit 14 gives driver full-path test pass, refreshed on each run.
// - Bit 13 flags resistance above upper threshold, refreshed on each test.
// - Bit 12 flags resistance below lower threshold, refreshed on each test.
// - Low mode: bits 11 to 8 give resistance channel, above seven means none.
// - Bit 7 flags a short between loops.
// - Bit 6 flags a short to ground, from the leakage test only.
// - All fields zero after power-on; a watchdog or system state reset zeroes only fields with no event in that cycle.
// - Bit 5 flags a short to battery, from the leakage test only.
// - Bit 4 gives leakage pin side, zero low side, one high side.
// - Bits 3 to 0 give leakage channel; codes eight upward mean none.
module loop_diag_result (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic system_state_reset,
  input wire logic watchdog_state_reset,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic [19:0] host_data,
  output logic rsp_valid,
  output logic [19:0] rsp_data,
  output logic cmd_refused,
  input wire logic sm_update,
  input wire logic sm_high_mode,
  input wire logic sm_test_running,
  input wire logic sm_prior_fault,
  input wire logic sm_loop_short,
  input wire logic [3:0] sm_select,
  input wire logic in_diag_state,
  input wire logic high_switch_on,
  input wire logic low_switch_on,
  input wire logic path_test_done,
  input wire logic path_test_pass,
  input wire logic res_test_done,
  input wire logic res_above,
  input wire logic res_below,
  input wire logic leak_done,
  input wire logic leak_ground,
  input wire logic leak_battery,
  input wire logic leak_high_pin,
  input wire logic [3:0] leak_channel
);
  logic clear;
  logic mode_q;
  logic high_test_running_q;
  logic prior_fault_flag_q;
  logic switch_active_flag_q;
  logic driver_path_pass_q;
  logic resistance_above_upper_q;
  logic resistance_below_lower_q;
  logic [3:0] select_q;
  logic loop_short_flag_q;
  logic ground_short_flag_q;
  logic battery_short_flag_q;
  logic leak_pin_side_q;
  logic [3:0] leakage_channel_q;
  logic [19:0] word;

  // Normalises a select code so software never sees an undefined value.
  function automatic logic [3:0] ldr_norm_select(input logic high, input logic [3:0] code);
    if (high) begin
      if (code > ldr_pkg::LDR_CH_MAX || code == ldr_pkg::LDR_TEST_UNUSED) begin
        ldr_norm_select = ldr_pkg::LDR_TEST_NONE;
      end else begin
        ldr_norm_select = code;
      end
    end else if (code > ldr_pkg::LDR_CH_MAX) begin
      ldr_norm_select = ldr_pkg::LDR_CH_NONE;
    end else begin
      ldr_norm_select = code;
    end
  endfunction : ldr_norm_select

  // ---------------------------------------------------------------
  // State machine fields
  // ---------------------------------------------------------------
  // An update in the same cycle as a state reset wins, so no event is lost.
  assign clear = system_state_reset || watchdog_state_reset;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= 1'b0;
      high_test_running_q <= 1'b0;
    end else if (sm_update) begin
      mode_q <= sm_high_mode;
      high_test_running_q <= sm_high_mode && sm_test_running;
    end else if (clear) begin
      mode_q <= 1'b0;
      high_test_running_q <= 1'b0;
    end
  end

  // Fault history fields change only on a state machine update or a state reset.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prior_fault_flag_q <= 1'b0;
      loop_short_flag_q <= 1'b0;
    end else if (sm_update) begin
      prior_fault_flag_q <= sm_prior_fault;
      loop_short_flag_q <= sm_loop_short;
    end else if (clear) begin
      prior_fault_flag_q <= 1'b0;
      loop_short_flag_q <= 1'b0;
    end
  end

  // A state reset leaves channel zero here, not the none code, so zero is ambiguous.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      select_q <= ldr_pkg::LDR_NIBBLE_ZERO;
    end else if (sm_update) begin
      select_q <= ldr_norm_select(sm_high_mode, sm_select);
    end else if (clear) begin
      select_q <= ldr_pkg::LDR_NIBBLE_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // Switch and driver path fields
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      switch_active_flag_q <= 1'b0;
    end else if (in_diag_state && (high_switch_on || low_switch_on)) begin
      switch_active_flag_q <= 1'b1;
    end else if (clear) begin
      switch_active_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      driver_path_pass_q <= 1'b0;
    end else if (path_test_done) begin
      driver_path_pass_q <= path_test_pass;
    end else if (clear) begin
      driver_path_pass_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Resistance range fields
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resistance_above_upper_q <= 1'b0;
      resistance_below_lower_q <= 1'b0;
    end else if (res_test_done) begin
      resistance_above_upper_q <= res_above;
      resistance_below_lower_q <= res_below;
    end else if (clear) begin
      resistance_above_upper_q <= 1'b0;
      resistance_below_lower_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Leakage fields
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ground_short_flag_q <= 1'b0;
      battery_short_flag_q <= 1'b0;
      leak_pin_side_q <= 1'b0;
      leakage_channel_q <= ldr_pkg::LDR_NIBBLE_ZERO;
    end else if (leak_done) begin
      ground_short_flag_q <= leak_ground;
      battery_short_flag_q <= leak_battery;
      leak_pin_side_q <= leak_high_pin;
      leakage_channel_q <= ldr_norm_select(1'b0, leak_channel);
    end else if (clear) begin
      ground_short_flag_q <= 1'b0;
      battery_short_flag_q <= 1'b0;
      leak_pin_side_q <= 1'b0;
      leakage_channel_q <= ldr_pkg::LDR_NIBBLE_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // Word assembly and read port
  // ---------------------------------------------------------------
  always_comb begin
    word = ldr_pkg::LDR_RESULT_RESET;
    word[ldr_pkg::LDR_BIT_MODE] = mode_q;
    word[ldr_pkg::LDR_BIT_RUN] = high_test_running_q;
    word[ldr_pkg::LDR_BIT_ZERO] = 1'b0;
    word[ldr_pkg::LDR_BIT_PRIOR] = prior_fault_flag_q;
    word[ldr_pkg::LDR_BIT_SWITCH] = switch_active_flag_q;
    word[ldr_pkg::LDR_BIT_PATH] = driver_path_pass_q;
    word[ldr_pkg::LDR_BIT_ABOVE] = resistance_above_upper_q;
    word[ldr_pkg::LDR_BIT_BELOW] = resistance_below_lower_q;
    word[ldr_pkg::LDR_SEL_HI:ldr_pkg::LDR_SEL_LO] = select_q;
    word[ldr_pkg::LDR_BIT_LOOP] = loop_short_flag_q;
    word[ldr_pkg::LDR_BIT_GROUND] = ground_short_flag_q;
    word[ldr_pkg::LDR_BIT_BATTERY] = battery_short_flag_q;
    word[ldr_pkg::LDR_BIT_PIN] = leak_pin_side_q;
    word[ldr_pkg::LDR_LEAK_HI:ldr_pkg::LDR_LEAK_LO] = leakage_channel_q;
  end

  ldr_res_if res_link ();
  assign res_link.result = word;

  // Host data is deliberately left unconnected: nothing it carries is stored.
  ldr_read_port u_read_port (
    .clk(clk),
    .reset_n(reset_n),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .res(res_link.snk),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .cmd_refused(cmd_refused)
  );
endmodule : loop_diag_result

/* ldr_host.sv */
// Host model that sends command words to the result register's read port.
// Assumes the bench calls send one at a time, off the same clk.
`timescale 1ns/1ps
module ldr_host (
  input wire logic clk,
  output logic cmd_valid,
  output logic [15:0] cmd_code,
  output logic [19:0] host_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 16'h0000;
    host_data = 20'h00000;
  end
  // Only reads exist, so nothing is ever expected back from a write.
  task automatic send(input logic [15:0] code, input logic [19:0] junk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    host_data <= junk;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // Released lines show the inverse so that stale values cannot pass.
    cmd_code <= ~code;
    host_data <= ~junk;
  endtask : send
endmodule : ldr_host

/* loop_diag_result_props.sv */
// Checker for the result register read port.
// Assumes it is bound to loop_diag_result and sees only its ports.
`timescale 1ns/1ps
module ldr_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic system_state_reset,
  input wire logic watchdog_state_reset,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic rsp_valid,
  input wire logic [19:0] rsp_data,
  input wire logic cmd_refused,
  input wire logic sm_update,
  input wire logic in_diag_state,
  input wire logic high_switch_on,
  input wire logic low_switch_on,
  input wire logic path_test_done,
  input wire logic res_test_done,
  input wire logic res_above,
  input wire logic res_below,
  input wire logic leak_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_read;
    cmd_valid && cmd_code == ldr_pkg::LDR_READ_CODE;
  endsequence
  sequence s_clear;
    (system_state_reset || watchdog_state_reset) && !sm_update && !path_test_done
      && !res_test_done && !leak_done && !(in_diag_state && (high_switch_on || low_switch_on));
  endsequence
  sequence s_quiet;
    !sm_update && !path_test_done && !res_test_done && !leak_done
      && !(in_diag_state && (high_switch_on || low_switch_on));
  endsequence
  sequence s_range;
    res_test_done ##1 !res_test_done;
  endsequence
  a_read_answer: assert property (s_read |=> rsp_valid && !cmd_refused)
    else $error("read code not answered");
  a_refuse_other: assert property (cmd_valid && cmd_code != ldr_pkg::LDR_READ_CODE
    |=> cmd_refused && !rsp_valid) else $error("other code not refused");
  a_no_spurious: assert property (!cmd_valid |=> !rsp_valid && !cmd_refused)
    else $error("answer without command");
  a_data_holds: assert property (not s_read |=> $stable(rsp_data))
    else $error("read data moved without a read");
  a_bit17_zero: assert property (rsp_valid |-> !rsp_data[17])
    else $error("bit 17 not zero");
  a_low_idle: assert property (rsp_valid && !rsp_data[19] |-> !rsp_data[18])
    else $error("running flag in low mode");
  a_low_select: assert property (rsp_valid && !rsp_data[19]
    |-> rsp_data[11:8] <= 4'h7 || rsp_data[11:8] == 4'hf) else $error("bad channel");
  a_high_code: assert property (rsp_valid && rsp_data[19]
    |-> rsp_data[11:8] <= 4'h7 && rsp_data[11:8] != 4'h4) else $error("bad test");
  a_leak_code: assert property (rsp_valid
    |-> rsp_data[3:0] <= 4'h7 || rsp_data[3:0] == 4'hf) else $error("bad leak");
  a_state_clear: assert property (s_clear ##1 s_quiet ##1 s_read
    |=> rsp_data == 20'h00000) else $error("fields not cleared");
  a_res_fresh: assert property (s_range ##1 s_read
    |=> rsp_data[13] == $past(res_above, 3) && rsp_data[12] == $past(res_below, 3))
    else $error("range flags stale");
endmodule : ldr_props
bind loop_diag_result ldr_props u_ldr_props (.clk(clk), .reset_n(reset_n),
  .system_state_reset(system_state_reset), .watchdog_state_reset(watchdog_state_reset),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .cmd_refused(cmd_refused), .sm_update(sm_update), .in_diag_state(in_diag_state),
  .high_switch_on(high_switch_on), .low_switch_on(low_switch_on),
  .path_test_done(path_test_done), .res_test_done(res_test_done), .res_above(res_above),
  .res_below(res_below), .leak_done(leak_done));

/* loop_diag_result_bench.sv */
// Self-checking bench: random update events, each followed by a read; steps with no event may send a refused code first.
// Assumes ldr_host drives the command port; f holds the expected word, one entry per field.
`timescale 1ns/1ps
module loop_diag_result_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic system_state_reset = 1'b0, watchdog_state_reset = 1'b0, sm_update = 1'b0;
  logic sm_high_mode = 1'b0, sm_test_running = 1'b0, sm_prior_fault = 1'b0;
  logic sm_loop_short = 1'b0, in_diag_state = 1'b0, high_switch_on = 1'b0;
  logic low_switch_on = 1'b0, path_test_done = 1'b0, path_test_pass = 1'b0;
  logic res_test_done = 1'b0, res_above = 1'b0, res_below = 1'b0, leak_done = 1'b0;
  logic leak_ground = 1'b0, leak_battery = 1'b0, leak_high_pin = 1'b0;
  logic [3:0] sm_select = 4'h0, leak_channel = 4'h0;
  logic cmd_valid, rsp_valid, cmd_refused;
  logic [15:0] cmd_code;
  logic [19:0] host_data, rsp_data;
  int num_errors = 0, check_count = 0, cycles = 0, seed = 21;
  int f[20];
  initial forever #12.5 clk = ~clk;
  ldr_host u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .host_data(host_data));
  loop_diag_result u_loop_diag_result (.clk(clk), .reset_n(reset_n),
    .system_state_reset(system_state_reset), .watchdog_state_reset(watchdog_state_reset),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .host_data(host_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .cmd_refused(cmd_refused), .sm_update(sm_update),
    .sm_high_mode(sm_high_mode), .sm_test_running(sm_test_running),
    .sm_prior_fault(sm_prior_fault), .sm_loop_short(sm_loop_short), .sm_select(sm_select),
    .in_diag_state(in_diag_state), .high_switch_on(high_switch_on),
    .low_switch_on(low_switch_on), .path_test_done(path_test_done),
    .path_test_pass(path_test_pass), .res_test_done(res_test_done), .res_above(res_above),
    .res_below(res_below), .leak_done(leak_done), .leak_ground(leak_ground),
    .leak_battery(leak_battery), .leak_high_pin(leak_high_pin), .leak_channel(leak_channel));
  function automatic logic [19:0] expw();
    logic [19:0] w;
    w = 20'(f[8] << 8) | 20'(f[0]);
    for (int i = 4; i < 20; i++) begin
      if (i < 8 || i > 11) w[i] = f[i][0];
    end
    return w;
  endfunction : expw
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic read_check();
    u_host.send(ldr_pkg::LDR_READ_CODE, 20'($random(seed)));
    @(negedge clk);
    check("rsp_valid", {19'h0, rsp_valid}, 20'h00001);
    check("rsp_data", rsp_data, expw());
  endtask : read_check
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    logic [31:0] r;
    f = '{default: 0};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    read_check();
    repeat (120) begin
      r = $random(seed);
      @(posedge clk);
      case (r[30:28])
        3'd0: begin
          sm_update <= 1'b1;
          {sm_high_mode, sm_test_running, sm_prior_fault, sm_loop_short, sm_select} <= r[7:0];
          f[19] = r[7];
          f[18] = r[7] & r[6];
          f[16] = r[5];
          f[7] = r[4];
          if (r[7]) f[8] = (r[3:0] == 4'h4 || r[3:0] > 4'h7) ? 0 : r[3:0];
          else f[8] = (r[3:0] > 4'h7) ? 15 : r[3:0];
        end
        3'd1: begin
          path_test_done <= 1'b1;
          path_test_pass <= r[0];
          f[14] = r[0];
        end
        3'd2: begin
          res_test_done <= 1'b1;
          {res_above, res_below} <= r[1:0];
          f[13] = r[1];
          f[12] = r[0];
        end
        3'd3: begin
          leak_done <= 1'b1;
          {leak_ground, leak_battery, leak_high_pin, leak_channel} <= r[6:0];
          f[6] = r[6];
          f[5] = r[5];
          f[4] = r[4];
          f[0] = (r[3:0] > 4'h7) ? 15 : r[3:0];
        end
        3'd4: begin
          {in_diag_state, high_switch_on, low_switch_on} <= r[2:0];
          if (r[2] && r[1:0] != 2'b00) f[15] = 1;
        end
        3'd5: begin
          if (r[0]) system_state_reset <= 1'b1;
          else watchdog_state_reset <= 1'b1;
          f = '{default: 0};
        end
        default: ;
      endcase
      @(posedge clk);
      {sm_update, path_test_done, res_test_done, leak_done, in_diag_state} <= 5'h00;
      {high_switch_on, low_switch_on, system_state_reset, watchdog_state_reset} <= 4'h0;
      if (r[30:29] == 2'b11) begin
        u_host.send((r[15:0] == 16'h3700) ? 16'h3701 : r[15:0], r[19:0]);
        @(negedge clk);
        check("cmd_refused", {19'h0, cmd_refused}, 20'h00001);
        check("rsp_valid", {19'h0, rsp_valid}, 20'h00000);
      end
      read_check();
    end
    conclude();
  end
endmodule : loop_diag_result_bench
